// ==== gps_pkg.sv ====
/*
 * Package for the GPIO port with pin steering: register offsets, field layouts,
 * reset values, pin indices and the packed carriers shared by the design files.
 * Assumes a 32-bit APB slave with each register on one aligned word.
 */
package gps_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int GPS_PORT_W = 8;
	localparam int GPS_ADDR_W = 8;
	localparam int GPS_DATA_W = 32;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [GPS_ADDR_W-1:0] GPS_OFF_DIR_A = 8'h00;
	localparam logic [GPS_ADDR_W-1:0] GPS_OFF_PIN_A = 8'h04;
	localparam logic [GPS_ADDR_W-1:0] GPS_OFF_LAT_A = 8'h08;
	localparam logic [GPS_ADDR_W-1:0] GPS_OFF_ANS_A = 8'h0C;
	localparam logic [GPS_ADDR_W-1:0] GPS_OFF_DIR_C = 8'h10;
	localparam logic [GPS_ADDR_W-1:0] GPS_OFF_PIN_C = 8'h14;
	localparam logic [GPS_ADDR_W-1:0] GPS_OFF_LAT_C = 8'h18;
	localparam logic [GPS_ADDR_W-1:0] GPS_OFF_ANS_C = 8'h1C;
	localparam logic [GPS_ADDR_W-1:0] GPS_OFF_STEER0 = 8'h20;
	localparam logic [GPS_ADDR_W-1:0] GPS_OFF_STEER1 = 8'h24;

	// ----------------------------------------------------------------
	// Reset values and implemented-bit masks
	// ----------------------------------------------------------------
	localparam logic [7:0] GPS_DIR_RST = 8'hFF;
	localparam logic [7:0] GPS_LAT_RST = 8'h00;
	localparam logic [7:0] GPS_ANS_RST = 8'hFF;
	localparam logic [7:0] GPS_STEER_RST = 8'h00;
	localparam logic [7:0] GPS_STEER0_MASK = 8'hEC;
	localparam logic [7:0] GPS_STEER1_MASK = 8'h0F;

	// ----------------------------------------------------------------
	// Steering field positions
	// ----------------------------------------------------------------
	localparam int GPS_S0_RX = 7;
	localparam int GPS_S0_SDO = 6;
	localparam int GPS_S0_SS = 5;
	localparam int GPS_S0_TG = 3;
	localparam int GPS_S0_TX = 2;
	localparam int GPS_S1_PD = 3;
	localparam int GPS_S1_PC = 2;
	localparam int GPS_S1_P2B = 1;
	localparam int GPS_S1_CCP2 = 0;

	// ----------------------------------------------------------------
	// Pin indices within port A and port C
	// ----------------------------------------------------------------
	localparam int GPS_RA0 = 0;
	localparam int GPS_RA1 = 1;
	localparam int GPS_RA3 = 3;
	localparam int GPS_RA4 = 4;
	localparam int GPS_RA5 = 5;
	localparam int GPS_RC0 = 0;
	localparam int GPS_RC1 = 1;
	localparam int GPS_RC2 = 2;
	localparam int GPS_RC3 = 3;
	localparam int GPS_RC4 = 4;
	localparam int GPS_RC5 = 5;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	// Peripheral output functions: enable plus value; drive enables override direction
	typedef struct packed {
		logic tx_en;
		logic tx_val;
		logic sdo_en;
		logic sdo_val;
		logic pb_en;
		logic pb_val;
		logic pc_en;
		logic pc_val;
		logic pd_en;
		logic pd_val;
		logic p2b_en;
		logic p2b_val;
		logic ccp2_en;
		logic ccp2_val;
	} gps_periph_out_t;

	// Steered peripheral inputs returned to the peripherals
	typedef struct packed {
		logic rx;
		logic async_transmit_sync_clock;
		logic ss_n;
		logic tgate;
	} gps_periph_in_t;

	// Pin drive per port
	typedef struct packed {
		logic [GPS_PORT_W-1:0] out;
		logic [GPS_PORT_W-1:0] oe;
	} gps_pin_drive_t;

	// Per-port register set
	typedef struct packed {
		logic [GPS_PORT_W-1:0] dir;
		logic [GPS_PORT_W-1:0] lat;
		logic [GPS_PORT_W-1:0] ans;
	} gps_port_regs_t;

endpackage : gps_pkg

// ==== gps_steer.sv ====
/*
 * Combinational pin steering: applies peripheral value and direction overrides
 * to the pins that the steering fields select, and routes steered inputs back.
 * Assumes registered steering fields and unregistered, analog-masked pin levels from the parent.
 */
`timescale 1ns/10ps
module gps_steer (
	// Steering fields
	input wire logic [7:0] steer0,
	input wire logic [7:0] steer1,
	// Ordinary port drive from direction and latch
	input wire gps_pkg::gps_pin_drive_t base_a,
	input wire gps_pkg::gps_pin_drive_t base_c,
	// Peripherals
	input wire gps_pkg::gps_periph_out_t periph_out,
	output gps_pkg::gps_periph_in_t periph_in,
	// Pin levels after the input buffer
	input wire logic [gps_pkg::GPS_PORT_W-1:0] lvl_a,
	input wire logic [gps_pkg::GPS_PORT_W-1:0] lvl_c,
	// Resulting drive
	output gps_pkg::gps_pin_drive_t drv_a,
	output gps_pkg::gps_pin_drive_t drv_c
);
	import gps_pkg::*;

	// ----------------------------------------------------------------
	// Output overrides
	// ----------------------------------------------------------------
	// Only the selected pin is touched; the other keeps its port drive
	always_comb begin
		drv_a = base_a;
		drv_c = base_c;
		if (periph_out.tx_en) begin
			if (steer0[GPS_S0_TX]) begin
				drv_c.out[GPS_RC4] = periph_out.tx_val;
				drv_c.oe[GPS_RC4] = 1'b1;
			end else begin
				drv_a.out[GPS_RA0] = periph_out.tx_val;
				drv_a.oe[GPS_RA0] = 1'b1;
			end
		end
		if (periph_out.sdo_en) begin
			if (steer0[GPS_S0_SDO]) begin
				drv_a.out[GPS_RA4] = periph_out.sdo_val;
				drv_a.oe[GPS_RA4] = 1'b1;
			end else begin
				drv_c.out[GPS_RC2] = periph_out.sdo_val;
				drv_c.oe[GPS_RC2] = 1'b1;
			end
		end
		if (periph_out.pb_en) begin // Fixed pin, not steerable
			drv_c.out[GPS_RC4] = periph_out.pb_val;
			drv_c.oe[GPS_RC4] = 1'b1;
		end
		if (periph_out.pc_en) begin
			if (steer1[GPS_S1_PC]) begin
				drv_c.out[GPS_RC1] = periph_out.pc_val;
				drv_c.oe[GPS_RC1] = 1'b1;
			end else begin
				drv_c.out[GPS_RC3] = periph_out.pc_val;
				drv_c.oe[GPS_RC3] = 1'b1;
			end
		end
		if (periph_out.pd_en) begin
			if (steer1[GPS_S1_PD]) begin
				drv_c.out[GPS_RC0] = periph_out.pd_val;
				drv_c.oe[GPS_RC0] = 1'b1;
			end else begin
				drv_c.out[GPS_RC2] = periph_out.pd_val;
				drv_c.oe[GPS_RC2] = 1'b1;
			end
		end
		if (periph_out.p2b_en) begin
			if (steer1[GPS_S1_P2B]) begin
				drv_a.out[GPS_RA4] = periph_out.p2b_val;
				drv_a.oe[GPS_RA4] = 1'b1;
			end else begin
				drv_c.out[GPS_RC2] = periph_out.p2b_val;
				drv_c.oe[GPS_RC2] = 1'b1;
			end
		end
		if (periph_out.ccp2_en) begin
			if (steer1[GPS_S1_CCP2]) begin
				drv_a.out[GPS_RA5] = periph_out.ccp2_val;
				drv_a.oe[GPS_RA5] = 1'b1;
			end else begin
				drv_c.out[GPS_RC3] = periph_out.ccp2_val;
				drv_c.oe[GPS_RC3] = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Input routing
	// ----------------------------------------------------------------
	// Receive and gate inputs come from the selected alternative only
	always_comb begin
		periph_in.rx = steer0[GPS_S0_RX] ? lvl_c[GPS_RC5] : lvl_a[GPS_RA1];
		periph_in.async_transmit_sync_clock = steer0[GPS_S0_TX] ? lvl_c[GPS_RC4] : lvl_a[GPS_RA0];
		periph_in.ss_n = steer0[GPS_S0_SS] ? lvl_a[GPS_RA3] : lvl_c[GPS_RC3];
		periph_in.tgate = steer0[GPS_S0_TG] ? lvl_a[GPS_RA3] : lvl_a[GPS_RA4];
	end

endmodule : gps_steer

// ==== gps_top.sv ====
/*
 * GPIO port pair with alternate pin steering behind an APB slave.
 * Holds direction, latch and analog-select per port plus two steering registers.
 * Assumes pin inputs synchronous to ref_clk; pin wires are resolved outside.
 */
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - Each port has a direction register, a pin-level register and an output latch.
// - Writing the latch register acts exactly like writing the pin-level register.
// - Latch reads return latch contents; pin-level reads return actual pin levels.
// - Analog-select bits disable each pin's digital input buffer.
// - An enabled peripheral takes its pin away from ordinary port use.
// - Two steering registers choose the pin for each steerable function.
// - Steerable: receive/transmit pair, serial out, slave select, timer gate, PWM, capture.
// - Steering changes never alter stored direction bits.
// - Peripheral value and direction overrides go to the selected pin.
// - The unselected alternative pin keeps its ordinary port behaviour.
// - Direction one makes an input; zero drives the latch value out.
module gps_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gps_pkg::GPS_ADDR_W-1:0] paddr,
	input wire logic [gps_pkg::GPS_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [gps_pkg::GPS_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port A pins
	input wire logic [gps_pkg::GPS_PORT_W-1:0] pa_in,
	output logic [gps_pkg::GPS_PORT_W-1:0] pa_out,
	output logic [gps_pkg::GPS_PORT_W-1:0] pa_oe,
	// Port C pins
	input wire logic [gps_pkg::GPS_PORT_W-1:0] pc_in,
	output logic [gps_pkg::GPS_PORT_W-1:0] pc_out,
	output logic [gps_pkg::GPS_PORT_W-1:0] pc_oe,
	// Peripheral functions
	input wire gps_pkg::gps_periph_out_t periph_out,
	output gps_pkg::gps_periph_in_t periph_in
);
	import gps_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		gps_port_regs_t pa;
		gps_port_regs_t pc;
		logic [7:0] steer0;
		logic [7:0] steer1;
		logic [GPS_DATA_W-1:0] rdata;
		logic ready;
		logic err;
		gps_pin_drive_t da;
		gps_pin_drive_t dc;
		gps_periph_in_t pin_fn;
	} gps_state_t;

	gps_state_t st_ff;
	gps_state_t nxt_st;

	gps_pin_drive_t base_a;
	gps_pin_drive_t base_c;
	gps_pin_drive_t steer_a;
	gps_pin_drive_t steer_c;
	gps_periph_in_t fn_in;
	logic [GPS_PORT_W-1:0] lvl_a;
	logic [GPS_PORT_W-1:0] lvl_c;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte-lane merge of the low lane; registers are 8 bits wide
	function automatic logic [7:0] gps_merge(input logic [7:0] old, input logic [GPS_DATA_W-1:0] wd,
		input logic [3:0] strb, input logic [7:0] mask);
		gps_merge = strb[0] ? (wd[7:0] & mask) : old;
	endfunction : gps_merge

	// Zero-extend a byte onto the data bus
	function automatic logic [GPS_DATA_W-1:0] gps_ext(input logic [7:0] b);
		gps_ext = {{(GPS_DATA_W-8){1'b0}}, b};
	endfunction : gps_ext

	// ----------------------------------------------------------------
	// Pin path
	// ----------------------------------------------------------------
	// Analog-selected pins read low so the digital buffer is idle
	assign lvl_a = pa_in & ~st_ff.pa.ans;
	assign lvl_c = pc_in & ~st_ff.pc.ans;

	// Ordinary drive: direction one disables the driver
	assign base_a.out = st_ff.pa.lat;
	assign base_a.oe = ~st_ff.pa.dir;
	assign base_c.out = st_ff.pc.lat;
	assign base_c.oe = ~st_ff.pc.dir;

	// Peripheral overrides on the steered pins
	gps_steer u_steer (
		.steer0(st_ff.steer0),
		.steer1(st_ff.steer1),
		.base_a(base_a),
		.base_c(base_c),
		.periph_out(periph_out),
		.periph_in(fn_in),
		.lvl_a(lvl_a),
		.lvl_c(lvl_c),
		.drv_a(steer_a),
		.drv_c(steer_c)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Zero-wait APB: pready rises in the access cycle after setup
	always_comb begin
		logic wr;
		logic rd;
		wr = 1'b0;
		rd = 1'b0;
		nxt_st = st_ff;
		nxt_st.ready = 1'b0;
		nxt_st.err = 1'b0;
		nxt_st.da = steer_a;
		nxt_st.dc = steer_c;
		nxt_st.pin_fn = fn_in;
		// Setup seen: answer registered so that pready comes from a flop
		if (psel && !penable) begin
			nxt_st.ready = 1'b1;
			wr = pwrite;
			rd = !pwrite;
			nxt_st.rdata = '0;
			case (paddr)
				GPS_OFF_DIR_A: begin
					if (wr) nxt_st.pa.dir = gps_merge(st_ff.pa.dir, pwdata, pstrb, 8'hFF);
					if (rd) nxt_st.rdata = gps_ext(st_ff.pa.dir);
				end
				GPS_OFF_PIN_A, GPS_OFF_LAT_A: begin
					// Both offsets write the latch; reads differ
					if (wr) nxt_st.pa.lat = gps_merge(st_ff.pa.lat, pwdata, pstrb, 8'hFF);
					if (rd) begin
						nxt_st.rdata = gps_ext((paddr == GPS_OFF_PIN_A) ? lvl_a : st_ff.pa.lat);
					end
				end
				GPS_OFF_ANS_A: begin
					if (wr) nxt_st.pa.ans = gps_merge(st_ff.pa.ans, pwdata, pstrb, 8'hFF);
					if (rd) nxt_st.rdata = gps_ext(st_ff.pa.ans);
				end
				GPS_OFF_DIR_C: begin
					if (wr) nxt_st.pc.dir = gps_merge(st_ff.pc.dir, pwdata, pstrb, 8'hFF);
					if (rd) nxt_st.rdata = gps_ext(st_ff.pc.dir);
				end
				GPS_OFF_PIN_C, GPS_OFF_LAT_C: begin
					if (wr) nxt_st.pc.lat = gps_merge(st_ff.pc.lat, pwdata, pstrb, 8'hFF);
					if (rd) begin
						nxt_st.rdata = gps_ext((paddr == GPS_OFF_PIN_C) ? lvl_c : st_ff.pc.lat);
					end
				end
				GPS_OFF_ANS_C: begin
					if (wr) nxt_st.pc.ans = gps_merge(st_ff.pc.ans, pwdata, pstrb, 8'hFF);
					if (rd) nxt_st.rdata = gps_ext(st_ff.pc.ans);
				end
				GPS_OFF_STEER0: begin
					// Only the steering field changes; direction bits stay put
					if (wr) nxt_st.steer0 = gps_merge(st_ff.steer0, pwdata, pstrb, GPS_STEER0_MASK);
					if (rd) nxt_st.rdata = gps_ext(st_ff.steer0 & GPS_STEER0_MASK);
				end
				GPS_OFF_STEER1: begin
					if (wr) nxt_st.steer1 = gps_merge(st_ff.steer1, pwdata, pstrb, GPS_STEER1_MASK);
					if (rd) nxt_st.rdata = gps_ext(st_ff.steer1 & GPS_STEER1_MASK);
				end
				default: begin
					nxt_st.err = 1'b1; // Unmapped: error, no write, zero data
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Pins float as inputs after reset; steering on default pins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_ff.pa.dir <= GPS_DIR_RST;
			st_ff.pa.lat <= GPS_LAT_RST;
			st_ff.pa.ans <= GPS_ANS_RST;
			st_ff.pc.dir <= GPS_DIR_RST;
			st_ff.pc.lat <= GPS_LAT_RST;
			st_ff.pc.ans <= GPS_ANS_RST;
			st_ff.steer0 <= GPS_STEER_RST;
			st_ff.steer1 <= GPS_STEER_RST;
			st_ff.rdata <= '0;
			st_ff.ready <= 1'b0;
			st_ff.err <= 1'b0;
			st_ff.da <= '0;
			st_ff.dc <= '0;
			st_ff.pin_fn <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Pin drive lags register writes by one cycle, the price of flopped outputs
	assign prdata = st_ff.rdata;
	assign pready = st_ff.ready;
	assign pslverr = st_ff.err;
	assign pa_out = st_ff.da.out;
	assign pa_oe = st_ff.da.oe;
	assign pc_out = st_ff.dc.out;
	assign pc_oe = st_ff.dc.oe;
	assign periph_in = st_ff.pin_fn;

endmodule : gps_top

// ==== gps_chk.sv ====
/*
 * Checker for gps_top: APB answer, read data and pin drive.
 * Assumes a bind onto gps_top; it sees that module's ports only.
 */
`timescale 1ns/10ps
module gps_chk (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gps_pkg::GPS_ADDR_W-1:0] paddr,
	input wire logic [gps_pkg::GPS_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [gps_pkg::GPS_DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Port A, port C drive and peripherals
	input wire logic [gps_pkg::GPS_PORT_W-1:0] pa_in,
	input wire logic [gps_pkg::GPS_PORT_W-1:0] pa_out,
	input wire logic [gps_pkg::GPS_PORT_W-1:0] pa_oe,
	input wire logic [gps_pkg::GPS_PORT_W-1:0] pc_out,
	input wire logic [gps_pkg::GPS_PORT_W-1:0] pc_oe,
	input wire gps_pkg::gps_periph_out_t periph_out,
	input wire gps_pkg::gps_periph_in_t periph_in
);
	import gps_pkg::*;
	logic [7:0] da_ff, la_ff, aa_ff, s0_ff, s1_ff;
	logic su;
	// Setup cycle; writes land at its edge
	assign su = psel && !penable;
	// Shadow registers, so pins can be tied to what software wrote
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			da_ff <= GPS_DIR_RST;
			la_ff <= GPS_LAT_RST;
			aa_ff <= GPS_ANS_RST;
			s0_ff <= GPS_STEER_RST;
			s1_ff <= GPS_STEER_RST;
		end else if (su && pwrite && pstrb[0]) begin
			if (paddr == GPS_OFF_DIR_A) da_ff <= pwdata[7:0];
			if (paddr == GPS_OFF_PIN_A || paddr == GPS_OFF_LAT_A) la_ff <= pwdata[7:0];
			if (paddr == GPS_OFF_ANS_A) aa_ff <= pwdata[7:0];
			if (paddr == GPS_OFF_STEER0) s0_ff <= pwdata[7:0] & GPS_STEER0_MASK;
			if (paddr == GPS_OFF_STEER1) s1_ff <= pwdata[7:0] & GPS_STEER1_MASK;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	property p_ack;
		su |=> pready;
	endproperty
	a_ack: assert property (p_ack) else $error("no answer");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("long ready");
	property p_err;
		su && paddr > 8'h27 |=> pready && pslverr;
	endproperty
	a_err: assert property (p_err) else $error("no error");
	property p_ok;
		su && paddr <= GPS_OFF_STEER1 && paddr[1:0] == 2'h0 |=> !pslverr;
	endproperty
	a_ok: assert property (p_ok) else $error("false error");
	property p_lat;
		su && !pwrite && paddr == GPS_OFF_LAT_A |=> prdata == {24'h0, la_ff};
	endproperty
	a_lat: assert property (p_lat) else $error("latch read");
	property p_steer;
		su && !pwrite && paddr == GPS_OFF_STEER0 |=> prdata == {24'h0, s0_ff};
	endproperty
	a_steer: assert property (p_steer) else $error("steer read");
	property p_gpio;
		1'b1 |=> pa_oe[2] == !$past(da_ff[2]) && (!pa_oe[2] || pa_out[2] == $past(la_ff[2]));
	endproperty
	a_gpio: assert property (p_gpio) else $error("plain pin drive");
	property p_tx;
		!s0_ff[GPS_S0_TX] && periph_out.tx_en |=> pa_oe[GPS_RA0] && pa_out[GPS_RA0] == $past(periph_out.tx_val);
	endproperty
	a_tx: assert property (p_tx) else $error("override missing");
	property p_keep;
		s0_ff[GPS_S0_TX] |=> pa_oe[GPS_RA0] == !$past(da_ff[GPS_RA0]);
	endproperty
	a_keep: assert property (p_keep) else $error("unselected pin hit");
	property p_rx;
		!s0_ff[GPS_S0_RX] |=> periph_in.rx == ($past(pa_in[GPS_RA1]) && !$past(aa_ff[GPS_RA1]));
	endproperty
	a_rx: assert property (p_rx) else $error("receive input");
	// Capture output is assigned last, so it owns its selected pin outright
	property p_ccp2_a;
		periph_out.ccp2_en && s1_ff[GPS_S1_CCP2] |=> pa_oe[GPS_RA5] && pa_out[GPS_RA5] == $past(periph_out.ccp2_val);
	endproperty
	a_ccp2_a: assert property (p_ccp2_a) else $error("capture output not on alternate pin");
	property p_ccp2_c;
		periph_out.ccp2_en && !s1_ff[GPS_S1_CCP2] |=> pc_oe[GPS_RC3] && pc_out[GPS_RC3] == $past(periph_out.ccp2_val);
	endproperty
	a_ccp2_c: assert property (p_ccp2_c) else $error("capture output not on default pin");
	property p_gate;
		s0_ff[GPS_S0_TG] |=> periph_in.tgate == ($past(pa_in[GPS_RA3]) && !$past(aa_ff[GPS_RA3]));
	endproperty
	a_gate: assert property (p_gate) else $error("gate input");
endmodule : gps_chk

// ==== gps_pad_model.sv ====
/*
 * Far-side pad model: resolves each pad from the block's drive and an outside source.
 * Assumes the outside source always drives, so no pad floats.
 */
`timescale 1ns/10ps
module gps_pad_model (
	// Block drive
	input wire logic [7:0] pa_out,
	input wire logic [7:0] pa_oe,
	input wire logic [7:0] pc_out,
	input wire logic [7:0] pc_oe,
	// Outside sources
	input wire logic [7:0] ext_a,
	input wire logic [7:0] ext_c,
	// Pad levels back to the block
	output logic [7:0] pa_in,
	output logic [7:0] pc_in
);
	// An enabled driver wins; otherwise the outside world sets the level
	assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
	assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);
endmodule : gps_pad_model

// ==== gps_tb_top.sv ====
/*
 * Testbench for gps_top: register access, pad levels, steering and reset.
 * Assumes gps_pkg, gps_chk and gps_pad_model are compiled first.
 */
`timescale 1ns/10ps
module gps_tb_top;
	import gps_pkg::*;
	// ----
	// Signals
	// ----
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic [7:0] pa_in, pa_out, pa_oe, pc_in, pc_out, pc_oe, v, w;
	logic [7:0] ext_a = 8'h00;
	logic [7:0] ext_c = 8'h00;
	logic [7:0] rv[10] = '{GPS_DIR_RST, 8'h00, GPS_LAT_RST, GPS_ANS_RST, GPS_DIR_RST, 8'h00, GPS_LAT_RST,
		GPS_ANS_RST, GPS_STEER_RST, GPS_STEER_RST};
	gps_periph_out_t periph_out = 14'h0;
	gps_periph_in_t periph_in;
	logic [33:0] q[$];
	logic [33:0] e;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	gps_top DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pa_in(pa_in),
		.pa_out(pa_out), .pa_oe(pa_oe), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe), .periph_out(periph_out),
		.periph_in(periph_in));
	gps_pad_model u_pads (.pa_out(pa_out), .pa_oe(pa_oe), .pc_out(pc_out), .pc_oe(pc_oe), .ext_a(ext_a),
		.ext_c(ext_c), .pa_in(pa_in), .pc_in(pc_in));
	// Clock
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// Watcher: oldest note against each finished transfer; also cuts a hang short
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 5000) begin
			n_errors++;
			close_out();
		end else if (psel && penable && pready === 1'b1) begin
			e = q.pop_front();
			n_compared++;
			if (pslverr !== e[32] || (!e[33] && prdata !== e[31:0])) begin
				n_errors++;
				$display("ERROR t=%0t got %h/%h exp %h/%h", $time, pslverr, prdata, e[32], e[31:0]);
			end
		end
	end
	// One APB transfer; the request stays up, so back-to-back calls need no gap
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
		q.push_back({wr, x});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
	endtask : xfer
	task automatic idle(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge ref_clk);
	endtask : idle
	task automatic close_out();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	// ----
	// Tests
	// ----
	initial begin
		void'($urandom(81));
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		for (int i = 0; i < 10; i++) xfer(1'b0, 8'(i * 4), 32'h0, {9'h0, rv[i]});
		xfer(1'b1, 8'h28, 32'hFF, {1'b1, 32'h0});
		xfer(1'b0, 8'hFC, 32'h0, {1'b1, 32'h0});
		idle(1);
		$display("test reset and map done");
		// Latch, pad and analog reads on both ports
		for (int p = 0; p < 2; p++) begin
			v = 8'($urandom());
			w = 8'($urandom());
			xfer(1'b1, GPS_OFF_PIN_A + 8'(p * 16), {24'h0, v}, 33'h0);
			xfer(1'b0, GPS_OFF_LAT_A + 8'(p * 16), 32'h0, {25'h0, v});
			xfer(1'b1, GPS_OFF_ANS_A + 8'(p * 16), 32'hF0, 33'h0);
			xfer(1'b1, GPS_OFF_DIR_A + 8'(p * 16), 32'h0, 33'h0);
			if (p == 1) ext_c <= w;
			else ext_a <= w;
			idle(3);
			xfer(1'b0, GPS_OFF_PIN_A + 8'(p * 16), 32'h0, {25'h0, v & 8'h0F});
			xfer(1'b1, GPS_OFF_DIR_A + 8'(p * 16), 32'hFF, 33'h0);
			idle(3);
			xfer(1'b0, GPS_OFF_PIN_A + 8'(p * 16), 32'h0, {25'h0, w & 8'h0F});
		end
		idle(1);
		$display("test pads done");
		// Random steering under busy peripherals; direction must survive
		for (int i = 0; i < 24; i++) begin
			v = 8'($urandom());
			xfer(1'b1, GPS_OFF_DIR_A, {24'h0, v}, 33'h0);
			xfer(1'b1, GPS_OFF_STEER0, $urandom(), 33'h0);
			xfer(1'b1, GPS_OFF_STEER1, $urandom(), 33'h0);
			periph_out <= gps_periph_out_t'(14'($urandom()));
			ext_a <= 8'($urandom());
			ext_c <= 8'($urandom());
			idle(5);
			xfer(1'b0, GPS_OFF_DIR_A, 32'h0, {25'h0, v});
		end
		xfer(1'b1, GPS_OFF_STEER0, 32'hFF, 33'h0);
		xfer(1'b1, GPS_OFF_STEER1, 32'hFF, 33'h0);
		xfer(1'b0, GPS_OFF_STEER0, 32'h0, {25'h0, GPS_STEER0_MASK});
		xfer(1'b0, GPS_OFF_STEER1, 32'h0, {25'h0, GPS_STEER1_MASK});
		// Low lane strobe off: the write must be dropped
		pstrb <= 4'hE;
		xfer(1'b1, GPS_OFF_DIR_A, ~{24'h0, v}, 33'h0);
		pstrb <= 4'hF;
		xfer(1'b0, GPS_OFF_DIR_A, 32'h0, {25'h0, v});
		idle(1);
		$display("test steering done");
		// Second reset in mid-run clears steering
		rst <= 1'b1;
		idle(2);
		rst <= 1'b0;
		idle(1);
		xfer(1'b0, GPS_OFF_STEER0, 32'h0, 33'h0);
		xfer(1'b0, GPS_OFF_STEER1, 32'h0, 33'h0);
		idle(2);
		$display("test second reset done");
		close_out();
	end
endmodule : gps_tb_top
bind gps_top gps_chk u_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pc_out(pc_out), .pc_oe(pc_oe), .periph_out(periph_out),
	.periph_in(periph_in));
